// ---- rtl/pbsi_pkg.sv ----
/*
 pbsi_pkg: constants shared by the power button / standby input block.
 assumes a 10 MHz system clock; times held in their own units.
*/
package pbsi_pkg;
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_CLEAR = 3'h2;
	localparam logic [2:0] ADDR_MASK = 3'h3;
	localparam logic [2:0] ADDR_SENSE = 3'h4;
	// control field positions
	localparam int unsigned CTRL_DBNC_LSB = 0;
	localparam int unsigned CTRL_DELAY_LSB = 2;
	localparam int unsigned CTRL_RST_EN_BIT = 4;
	localparam int unsigned CTRL_STBY_INV_BIT = 5;
	localparam logic [5:0] CTRL_RST_VAL = 6'h00;
	localparam logic [7:0] MASK_RST_VAL = 8'h7F;
	// sense field positions
	localparam int unsigned SENSE_PWR_BIT = 0;
	localparam int unsigned SENSE_STBY_BIT = 1;
	localparam int unsigned SENSE_MODE_BIT = 2;
	localparam int unsigned SENSE_ON_BIT = 3;
	// interrupt latch positions
	localparam int unsigned INT_PUSH = 0;
	localparam int unsigned INT_REL = 1;
	localparam int unsigned INT_HELD_LSB = 2;
	localparam int unsigned NUM_HELD = 5;
	localparam int unsigned NUM_INT = 7;
	// timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
	localparam logic [9:0] T_DBNC_SHORT_MS = 10'd32;
	localparam logic [9:0] T_DBNC_MID_MS = 10'd125;
	localparam logic [9:0] T_DBNC_LONG_MS = 10'd750;
	localparam logic [14:0] T_HOLD_MS [NUM_HELD] = '{15'd1000, 15'd2000, 15'd3000,
		15'd4000, 15'd8000};
	localparam logic [14:0] T_LONG_2S_MS = 15'd2000;
	localparam logic [14:0] T_LONG_4S_MS = 15'd4000;
	localparam logic [14:0] T_LONG_8S_MS = 15'd8000;
	localparam logic [14:0] T_LONG_16S_MS = 15'd16000;
	localparam int unsigned T_DISCHARGE_NS = 30000;
	localparam logic [8:0] DISCHARGE_CYC =
		9'((T_DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ON = 2'b01,
		ST_RST = 2'b11
	} pbsi_state_t;
endpackage

// ---- rtl/pbsi_top.sv ----
/*
 pbsi_top: power-on input (level or push-button mode) and standby input
 handling, with interrupt latches, mask and a plain register port.
 assumes one-time-programmed defaults are static pins, and that the
 power sequencer acts on the event and state outputs.
*/
// Local design decisions: the register addresses and the plain strobed port.
// Contract
// - one-time mode bit picks input mode
// - mode 0: level sensitive, high powers on
// - mode 1: low pressed, high released
// - sense bit is inverse of input
// - falling debounce 32/32/125/750 ms, rising 32
// - debounce field reset from one-time default
// - debounced press powers on, raises interrupts
// - push latch on debounced low when on; code also sets it when off
// - release latch on debounced high when on
// - held latches at 1,2,3,4,8 s
// - reset: power down, wait 30 us, up
// - reset enable 1: long press resets
// - reset enable 0: long press turns off
// - long press 2/4/8/16 s, one-time default
// - standby follows asserted standby input
// - standby equals pin xor polarity bit
// - latch stays until software writes one
// - unmasked set latch pulls interrupt low
`timescale 1ns/1ps
module pbsi_top #(
	parameter int unsigned MS_CYCLES = pbsi_pkg::MS_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic power_on_input,
	input wire logic standby_input,
	input wire logic power_input_mode_default,
	input wire logic [1:0] power_input_debounce_default,
	input wire logic [1:0] long_press_delay_default,
	input wire logic [pbsi_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pbsi_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pbsi_pkg::DATA_W-1:0] reg_rdata,
	output logic irq_out_n,
	output logic system_on,
	output logic power_on_event,
	output logic turn_off_event,
	output logic device_reset_active,
	output logic standby_mode
);
	import pbsi_pkg::*;

	////////////////////////////////////////////////////////////////////
	// declarations

	logic pwr_s1;
	logic pwr_s2;
	logic stby_s1;
	logic stby_s2;
	logic [15:0] ms_cnt;
	logic ms_tick;
	logic load_defaults;
	logic mode_edge;
	logic [1:0] dbnc_sel;
	logic [1:0] delay_sel;
	logic rst_en;
	logic stby_inv;
	logic deb_level;
	logic [9:0] deb_cnt;
	logic [9:0] deb_limit;
	logic fall_evt;
	logic rise_evt;
	logic [14:0] hold_cnt;
	logic [14:0] long_limit;
	logic long_hit;
	logic long_done;
	logic [NUM_HELD-1:0] held_hit;
	pbsi_state_t state;
	pbsi_state_t next_state;
	logic [8:0] disch_cnt;
	logic disch_done;
	logic [NUM_INT-1:0] int_status;
	logic [NUM_INT-1:0] int_mask;
	logic [NUM_INT-1:0] int_set;
	logic [NUM_INT-1:0] int_clr;
	logic wr_ctrl;
	logic wr_clear;
	logic wr_mask;
	logic [DATA_W-1:0] next_rdata;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_s1 <= 1'b1;
			pwr_s2 <= 1'b1;
			stby_s1 <= 1'b0;
			stby_s2 <= 1'b0;
		end else begin
			pwr_s1 <= power_on_input;
			pwr_s2 <= pwr_s1;
			stby_s1 <= standby_input;
			stby_s2 <= stby_s1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// millisecond enable

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ms_cnt <= 16'h0000;
			ms_tick <= 1'b0;
		end else if (ms_cnt >= 16'(MS_CYCLES - 1)) begin
			ms_cnt <= 16'h0000;
			ms_tick <= 1'b1;
		end else begin
			ms_cnt <= ms_cnt + 16'h0001;
			ms_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// one-time defaults: caught after reset release, and again when a
	// forced reset powers back up

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			load_defaults <= 1'b1;
		end else begin
			load_defaults <= disch_done;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_edge <= 1'b0;
		end else if (load_defaults) begin
			mode_edge <= power_input_mode_default;
		end
	end

	////////////////////////////////////////////////////////////////////
	// control register

	assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
	assign wr_clear = reg_wr && reg_addr == ADDR_CLEAR;
	assign wr_mask = reg_wr && reg_addr == ADDR_MASK;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dbnc_sel <= CTRL_RST_VAL[CTRL_DBNC_LSB +: 2];
			delay_sel <= CTRL_RST_VAL[CTRL_DELAY_LSB +: 2];
			rst_en <= CTRL_RST_VAL[CTRL_RST_EN_BIT];
			stby_inv <= CTRL_RST_VAL[CTRL_STBY_INV_BIT];
		end else if (load_defaults) begin
			dbnc_sel <= power_input_debounce_default;
			delay_sel <= long_press_delay_default;
			rst_en <= CTRL_RST_VAL[CTRL_RST_EN_BIT];
			stby_inv <= CTRL_RST_VAL[CTRL_STBY_INV_BIT];
		end else if (wr_ctrl) begin
			dbnc_sel <= reg_wdata[CTRL_DBNC_LSB +: 2];
			delay_sel <= reg_wdata[CTRL_DELAY_LSB +: 2];
			rst_en <= reg_wdata[CTRL_RST_EN_BIT];
			stby_inv <= reg_wdata[CTRL_STBY_INV_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// debounce: deb_level 1 = high; resets low so level mode waits for a qualified high

	always_comb begin
		if (!deb_level) begin
			deb_limit = T_DBNC_SHORT_MS;
		end else begin
			unique case (dbnc_sel)
				2'b00: deb_limit = T_DBNC_SHORT_MS;
				2'b01: deb_limit = T_DBNC_SHORT_MS;
				2'b10: deb_limit = T_DBNC_MID_MS;
				2'b11: deb_limit = T_DBNC_LONG_MS;
			endcase
		end
	end

	// the first tick may come early, so one extra tick makes the
	// qualified time strictly longer than the setting
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			deb_level <= 1'b0;
			deb_cnt <= 10'h000;
			fall_evt <= 1'b0;
			rise_evt <= 1'b0;
		end else begin
			fall_evt <= 1'b0;
			rise_evt <= 1'b0;
			if (pwr_s2 == deb_level) begin
				deb_cnt <= 10'h000;
			end else if (ms_tick) begin
				if (deb_cnt >= deb_limit) begin
					deb_level <= pwr_s2;
					deb_cnt <= 10'h000;
					fall_evt <= !pwr_s2;
					rise_evt <= pwr_s2;
				end else begin
					deb_cnt <= deb_cnt + 10'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// hold timer and long press

	always_comb begin
		unique case (delay_sel)
			2'b00: long_limit = T_LONG_2S_MS;
			2'b01: long_limit = T_LONG_4S_MS;
			2'b10: long_limit = T_LONG_8S_MS;
			2'b11: long_limit = T_LONG_16S_MS;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hold_cnt <= 15'h0000;
		end else if (!(mode_edge && !deb_level && state == ST_ON)) begin
			hold_cnt <= 15'h0000;
		end else if (ms_tick && hold_cnt != 15'h7FFF) begin
			hold_cnt <= hold_cnt + 15'h0001;
		end
	end

	generate
		for (genvar i = 0; i < NUM_HELD; i++) begin : g_held
			assign held_hit[i] = ms_tick && hold_cnt == T_HOLD_MS[i];
		end
	endgenerate

	// one long-press action until hold_cnt clears (release or leaving on)
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			long_done <= 1'b0;
		end else if (hold_cnt == 15'h0000) begin
			long_done <= 1'b0;
		end else if (long_hit) begin
			long_done <= 1'b1;
		end
	end

	assign long_hit = ms_tick && hold_cnt >= long_limit && !long_done;

	////////////////////////////////////////////////////////////////////
	// power state

	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF: begin
				if (mode_edge ? fall_evt : deb_level) begin
					next_state = ST_ON;
				end
			end
			ST_ON: begin
				if (!mode_edge && !deb_level) begin
					next_state = ST_OFF;
				end else if (long_hit) begin
					next_state = rst_en ? ST_RST : ST_OFF;
				end
			end
			ST_RST: begin
				if (disch_done) begin
					next_state = ST_ON;
				end
			end
			default: next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// supplies discharge window during a forced reset
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			disch_cnt <= 9'h000;
		end else if (state != ST_RST) begin
			disch_cnt <= 9'h000;
		end else if (!disch_done) begin
			disch_cnt <= disch_cnt + 9'h001;
		end
	end

	assign disch_done = state == ST_RST && disch_cnt == DISCHARGE_CYC - 9'h001;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			system_on <= 1'b0;
			power_on_event <= 1'b0;
			turn_off_event <= 1'b0;
			device_reset_active <= 1'b0;
		end else begin
			system_on <= next_state == ST_ON;
			power_on_event <= next_state == ST_ON && state != ST_ON;
			turn_off_event <= next_state != ST_ON && state == ST_ON;
			device_reset_active <= next_state == ST_RST;
		end
	end

	////////////////////////////////////////////////////////////////////
	// standby

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			standby_mode <= 1'b0;
		end else begin
			standby_mode <= stby_s2 ^ stby_inv;
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt latches

	always_comb begin
		int_set = '0;
		int_set[INT_PUSH] = fall_evt && mode_edge &&
			(state == ST_ON || state == ST_OFF);
		int_set[INT_REL] = rise_evt && mode_edge && state == ST_ON;
		int_set[INT_HELD_LSB +: NUM_HELD] = held_hit;
	end

	assign int_clr = wr_clear ? reg_wdata[NUM_INT-1:0] : '0;

	// a set in the same cycle as its clear wins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status & ~int_clr) | int_set;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			int_mask <= MASK_RST_VAL[NUM_INT-1:0];
		end else if (wr_mask) begin
			int_mask <= reg_wdata[NUM_INT-1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= ~|(int_status & ~int_mask);
		end
	end

	////////////////////////////////////////////////////////////////////
	// register read port

	always_comb begin
		next_rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CTRL: begin
					next_rdata[CTRL_DBNC_LSB +: 2] = dbnc_sel;
					next_rdata[CTRL_DELAY_LSB +: 2] = delay_sel;
					next_rdata[CTRL_RST_EN_BIT] = rst_en;
					next_rdata[CTRL_STBY_INV_BIT] = stby_inv;
				end
				ADDR_STATUS: next_rdata[NUM_INT-1:0] = int_status;
				ADDR_MASK: next_rdata[NUM_INT-1:0] = int_mask;
				ADDR_SENSE: begin
					next_rdata[SENSE_PWR_BIT] = !pwr_s2;
					next_rdata[SENSE_STBY_BIT] = standby_mode;
					next_rdata[SENSE_MODE_BIT] = mode_edge;
					next_rdata[SENSE_ON_BIT] = system_on;
				end
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

// ---- test/pbsi_chk.sv ----
/*
 pbsi_chk: port-level checks of the power button and standby block.
 assumes it is bound to pbsi_top, one clock domain.
*/
`timescale 1ns/1ps
module pbsi_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic power_on_input,
	input wire logic standby_input,
	input wire logic [pbsi_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [pbsi_pkg::DATA_W-1:0] reg_rdata,
	input wire logic irq_out_n,
	input wire logic system_on,
	input wire logic power_on_event,
	input wire logic turn_off_event,
	input wire logic device_reset_active,
	input wire logic standby_mode
);
	import pbsi_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	a_on_pulse: assert property (power_on_event |=> !power_on_event)
		else $error("power on pulse too long");
	a_on_entry: assert property (power_on_event |-> system_on && !$past(system_on))
		else $error("power on without entry");
	a_off_entry: assert property ($fell(system_on) |-> turn_off_event)
		else $error("leaving on without turn off");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside slot");
	a_sense_read: assert property ($stable(power_on_input)[*6] ##0
		(reg_rd && reg_addr == ADDR_SENSE) |=>
		reg_rdata[SENSE_PWR_BIT] == !$past(power_on_input))
		else $error("sense bit wrong");
	a_stby_follow: assert property ($changed(standby_input) |-> ##[1:5] $changed(standby_mode))
		else $error("standby ignored pin");
	a_rst_wait: assert property ($rose(device_reset_active) |->
		##290 device_reset_active ##[1:15] power_on_event)
		else $error("discharge wait wrong");
	a_rst_entry: assert property ($rose(device_reset_active) |-> $past(system_on))
		else $error("reset not from on");
	a_irq_clear: assert property ($rose(irq_out_n) |->
		$past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
		else $error("irq released without write");
endmodule

// ---- test/pbsi_button.sv ----
/*
 pbsi_button: push button with pull-up, plus the standby driver.
 assumes the bench commands press and standby level.
*/
`timescale 1ns/1ps
module pbsi_button (
	input wire logic press,
	input wire logic stby_level,
	output logic pin_pwr,
	output logic pin_stby
);
	// pressed shorts to ground, else pull-up wins
	assign pin_pwr = press ? 1'b0 : 1'b1;
	assign pin_stby = stby_level;
endmodule

// ---- test/tb_top.sv ----
/*
 tb_top: self-checking bench for pbsi_top with a push button model.
 assumes MS_CYCLES of 4, so one ms is four clocks.
*/
`timescale 1ns/1ps
module tb_top;
	import pbsi_pkg::*;
	localparam int MS = 4;
	logic clk_sys = 0;
	logic sys_rst = 1;
	logic press = 0;
	logic stby = 0;
	logic mode = 1;
	logic [2:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] reg_rdata;
	logic [7:0] rnd = 8'h40;
	logic irq_out_n, system_on, power_on_event, turn_off_event;
	logic device_reset_active, standby_mode, power_on_input, standby_input;
	int mismatches = 0;
	int checked = 0;
	int n;
	int lim;
	always #50 clk_sys = ~clk_sys;
	pbsi_button u_btn(.press, .stby_level(stby), .pin_pwr(power_on_input),
		.pin_stby(standby_input));
	pbsi_top #(.MS_CYCLES(MS)) u_dut(.clk_sys, .sys_rst, .power_on_input, .standby_input,
		.power_input_mode_default(mode), .power_input_debounce_default(2'h0),
		.long_press_delay_default(2'h1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq_out_n, .system_on, .power_on_event, .turn_off_event,
		.device_reset_active, .standby_mode);
	////////////////////////////////////////
	function automatic logic [7:0] lfsr(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic int fall_ms(int c);
		return c == 3 ? 750 : c == 2 ? 125 : 32;
	endfunction
	function automatic logic sig(int s);
		case (s)
			0: return !irq_out_n;
			1: return turn_off_event;
			2: return device_reset_active;
			default: return power_on_event;
		endcase
	endfunction
	task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task automatic rd(logic [2:0] a, logic [7:0] exp, string nm);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 check(nm, exp, reg_rdata);
	endtask
	task automatic tk(int t);
		repeat (t * MS) @(posedge clk_sys);
	endtask
	// bounded wait, counts cycles into n
	task automatic await(int s, int lim);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (sig(s) !== 1'b1 && n < lim);
	endtask
	task automatic complete_run;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 0;
		repeat (2) @(posedge clk_sys);
		rd(ADDR_CTRL, 8'h04, "ctrl");
		rd(ADDR_MASK, MASK_RST_VAL, "mask");
		rd(ADDR_STATUS, 8'h00, "status");
		rd(ADDR_SENSE, 8'h04, "sense");
		wr(3'h7, 8'hFF);
		rd(3'h7, 8'h00, "unmapped");
		rnd = lfsr(rnd);
		wr(ADDR_MASK, rnd);
		rd(ADDR_MASK, rnd & 8'h7F, "mask");
		wr(ADDR_MASK, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, {2'h0, i[1], 5'h0});
			stby <= i[0];
			repeat (6) @(posedge clk_sys);
			#1 check("standby", 8'(i[0] ^ i[1]), 8'(standby_mode));
		end
		// short glitch, then a bounce that must restart the timer
		rnd = lfsr(rnd);
		@(posedge clk_sys);
		press <= 1;
		tk(int'(rnd % 8'd30) + 1);
		press <= 0;
		tk(40);
		check("glitch", 8'h00, 8'(system_on));
		press <= 1;
		tk(20);
		press <= 0;
		tk(2);
		for (int c = 0; c < 4; c++) begin
			if (c > 0) wr(ADDR_CTRL, 8'(c) | 8'h0C);
			press <= 1;
			await(0, 4000);
			lim = fall_ms(c);
			check("debounce", 8'h01, 8'(n >= lim * MS && n <= (lim + 2) * MS + 8));
			check("on", 8'h01, 8'(system_on));
			press <= 0;
			tk(40);
			rd(ADDR_STATUS, 8'h03, "status");
			wr(ADDR_MASK, 8'h7F);
			repeat (3) @(posedge clk_sys);
			#1 check("masked irq", 8'h01, 8'(irq_out_n));
			wr(ADDR_MASK, 8'h00);
			wr(ADDR_CLEAR, 8'h03);
			repeat (3) @(posedge clk_sys);
			#1 check("cleared irq", 8'h01, 8'(irq_out_n));
		end
		wr(ADDR_CTRL, 8'h0C);
		press <= 1;
		tk(8200);
		rd(ADDR_STATUS, 8'h7D, "held");
		press <= 0;
		tk(40);
		wr(ADDR_CLEAR, 8'h7F);
		wr(ADDR_CTRL, 8'h10);
		press <= 1;
		await(2, 9000);
		check("reset time", 8'h01, 8'(n >= 8000 && n <= 8400));
		await(3, 400);
		check("repower", 8'h01, 8'(n >= 290 && n <= 320));
		rd(ADDR_CTRL, 8'h04, "reload");
		press <= 0;
		tk(40);
		wr(ADDR_CLEAR, 8'h7F);
		wr(ADDR_CTRL, 8'h04);
		press <= 1;
		await(1, 17000);
		check("off time", 8'h01, 8'(n >= 16000 && n <= 16400));
		check("off", 8'h00, 8'(system_on));
		// level mode after a second reset
		mode <= 0;
		sys_rst <= 1;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 0;
		repeat (4) @(posedge clk_sys);
		#1 check("level early", 8'h00, 8'(system_on));
		tk(50);
		check("level low", 8'h00, 8'(system_on));
		rd(ADDR_SENSE, 8'h03, "sense");
		press <= 0;
		tk(40);
		check("level high", 8'h01, 8'(system_on));
		press <= 1;
		tk(40);
		check("level off", 8'h00, 8'(system_on));
		complete_run;
	end
	initial begin
		#(90000 * 100);
		mismatches++;
		complete_run;
	end
endmodule
bind pbsi_top pbsi_chk u_chk(.clk_sys, .sys_rst, .power_on_input, .standby_input,
	.reg_addr, .reg_wr, .reg_rd, .reg_rdata, .irq_out_n, .system_on, .power_on_event,
	.turn_off_event, .device_reset_active, .standby_mode);
